// file: inc/cbbc_defines.svh
/*
 * Constants for the carry branch and bit clear execution block:
 * register offsets, field positions, reset values, opcodes and bus responses.
 * Assumes it is included by bare name from design and bench files.
 */
`ifndef CBBC_DEFINES_SVH
`define CBBC_DEFINES_SVH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define CBBC_OFF_CTRL 12'h000
`define CBBC_OFF_BANK 12'h004
`define CBBC_OFF_IDXB 12'h008
`define CBBC_OFF_STAT 12'h00C
`define CBBC_OFF_CCNT 12'h010

// ==========================================================
// Field positions
`define CBBC_CTRL_EXT_BIT 0
`define CBBC_STAT_NOP_BIT 0
`define CBBC_STAT_CARRY_BIT 1
`define CBBC_STAT_TCNT_LSB 16

// ==========================================================
// Reset values
`define CBBC_RST_CTRL 1'h0
`define CBBC_RST_BANK 4'h0
`define CBBC_RST_IDXB 12'h000

// ==========================================================
// Instruction encoding
`define CBBC_OP_BRC 8'hE2
`define CBBC_OP_CLR 4'h9
`define CBBC_IDX_MAX 8'h5F
`define CBBC_ACC_SPLIT 8'h80
`define CBBC_ACC_HI_PAGE 4'hF
`define CBBC_PC_STEP 21'h00_0002

// ==========================================================
// Bus answers
`define CBBC_RESP_OKAY 2'h0
`define CBBC_RESP_SLVERR 2'h2

`endif

// file: inc/cbbc_pkg.sv
/*
 * Types for the carry branch and bit clear execution block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package cbbc_pkg;
   // ==========================================================
   // Quarter-cycle phase, one-hot
   typedef enum logic [3:0] {
      CBBC_Q1 = 4'b0001,
      CBBC_Q2 = 4'b0010,
      CBBC_Q3 = 4'b0100,
      CBBC_Q4 = 4'b1000
   } cbbc_phase_t;

   // ==========================================================
   // Execution state, one-hot
   typedef enum logic [1:0] {
      CBBC_ST_EXEC = 2'b01,  // Normal instruction cycle
      CBBC_ST_NOP = 2'b10    // Forced idle cycle after a taken branch
   } cbbc_state_t;
endpackage

`default_nettype wire

// file: src/cbbc_qgen.sv
/*
 * Quarter-cycle phase generator: four clocks make one instruction cycle.
 * Assumes a free running clock and a synchronous active high reset.
 */
`default_nettype none

module cbbc_qgen (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   output cbbc_pkg::cbbc_phase_t o_phase
);
   // ==========================================================
   // Phase rotation
   cbbc_pkg::cbbc_phase_t phase_r;  // Current quarter
   cbbc_pkg::cbbc_phase_t phase_nxt;  // Next quarter

   // Rotate one-hot through Q1..Q4
   always_comb begin
      case (phase_r)
         cbbc_pkg::CBBC_Q1: phase_nxt = cbbc_pkg::CBBC_Q2;
         cbbc_pkg::CBBC_Q2: phase_nxt = cbbc_pkg::CBBC_Q3;
         cbbc_pkg::CBBC_Q3: phase_nxt = cbbc_pkg::CBBC_Q4;
         default: phase_nxt = cbbc_pkg::CBBC_Q1;  // Also recovers bad codes
      endcase
   end

   // Phase register
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         phase_r <= cbbc_pkg::CBBC_Q1;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   assign o_phase = phase_r;
endmodule

`default_nettype wire

// file: src/cbbc_core.sv
/*
 * Execution block for the carry branch and the register bit clear,
 * with an AXI4-Lite register slave for mode, bank and status.
 * Assumes the fetch unit presents the word and its address at Q1,
 * and data memory answers combinationally to the address it is given.
 */
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`include "cbbc_defines.svh"
`default_nettype none

module cbbc_core #(
   parameter int PC_W = 21,
   parameter int DA_W = 12
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Fetch side
   input wire logic [15:0] i_instr,
   input wire logic [PC_W-1:0] i_pc,
   input wire logic i_carry,
   output logic o_pc_load,
   output logic [PC_W-1:0] o_pc_value,
   output logic o_flush,
   // Data memory side
   output logic [DA_W-1:0] o_dm_addr,
   output logic o_dm_rd,
   input wire logic [7:0] i_dm_rdata,
   output logic o_dm_wr,
   output logic [7:0] o_dm_wdata,
   // AXI4-Lite slave
   input wire logic [11:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [11:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready
);
   // ==========================================================
   // Phase and state
   cbbc_pkg::cbbc_phase_t phase;  // Current quarter
   cbbc_pkg::cbbc_state_t st_r;  // Execution state
   logic [15:0] ir_r;  // Latched instruction word
   logic [PC_W-1:0] pc_r;  // Address of the latched word
   logic carry_r;  // Carry sampled in Q3
   logic [7:0] mod_r;  // Modified register value
   logic ext_en_r;  // Extended instruction set enable
   logic [3:0] bank_r;  // Bank selection register
   logic [DA_W-1:0] idx_base_r;  // Base for indexed literal offset
   logic [15:0] taken_cnt_r;  // Taken branches
   logic [15:0] clr_cnt_r;  // Executed bit clears

   cbbc_qgen u_qgen (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .o_phase(phase)
   );

   // ==========================================================
   // Decode
   logic is_brc;  // Carry branch word
   logic is_clr;  // Bit clear word
   logic [2:0] bsel;  // Bit number b
   logic acc_a;  // Access bit a
   logic [7:0] fadr;  // File address f
   logic [PC_W-1:0] br_target;  // Branch destination
   logic [DA_W-1:0] op_addr;  // Resolved operand address
   logic exec_q;  // Working cycle, not the idle one

   assign is_brc = (ir_r[15:8] == `CBBC_OP_BRC);
   assign is_clr = (ir_r[15:12] == `CBBC_OP_CLR);
   assign bsel = ir_r[11:9];
   assign acc_a = ir_r[8];
   assign fadr = ir_r[7:0];
   assign exec_q = (st_r == cbbc_pkg::CBBC_ST_EXEC);
   // Sign extended offset doubled; the add wraps at the PC width
   assign br_target = PC_W'(pc_r + `CBBC_PC_STEP + PC_W'({{(PC_W-9){ir_r[7]}}, ir_r[7:0], 1'b0}));

   // Operand address: indexed, access bank or banked
   always_comb begin
      if (!acc_a && ext_en_r && (fadr <= `CBBC_IDX_MAX)) begin
         op_addr = DA_W'(idx_base_r + DA_W'(fadr));
      end else if (!acc_a) begin
         // Low half maps to page 0, high half to the top page
         op_addr = (fadr < `CBBC_ACC_SPLIT) ? DA_W'(fadr)
                 : DA_W'({`CBBC_ACC_HI_PAGE, fadr});
      end else begin
         op_addr = DA_W'({bank_r, fadr});
      end
   end

   // ==========================================================
   // Instruction latch and state
   // Word fetched during the idle cycle is the stale one: never latched
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         ir_r <= 16'h0000;
         pc_r <= '0;
      end else if (phase == cbbc_pkg::CBBC_Q1 && exec_q) begin
         ir_r <= i_instr;
         pc_r <= i_pc;
      end else if (phase == cbbc_pkg::CBBC_Q1) begin
         ir_r <= 16'h0000;
      end
   end

   // Taken branch enters one idle cycle; otherwise stay executing
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         st_r <= cbbc_pkg::CBBC_ST_EXEC;
      end else if (phase == cbbc_pkg::CBBC_Q4) begin
         case (st_r)
            cbbc_pkg::CBBC_ST_EXEC: begin
               if (is_brc && carry_r) begin
                  st_r <= cbbc_pkg::CBBC_ST_NOP;
               end
            end
            default: st_r <= cbbc_pkg::CBBC_ST_EXEC;
         endcase
      end
   end

   // ==========================================================
   // Branch path
   // Carry read while processing data in Q3
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         carry_r <= 1'b0;
      end else if (phase == cbbc_pkg::CBBC_Q3) begin
         carry_r <= i_carry;
      end
   end

   // PC write and flush only in Q4 of a taken branch
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_pc_load <= 1'b0;
         o_flush <= 1'b0;
         o_pc_value <= '0;
      end else begin
         o_pc_load <= (phase == cbbc_pkg::CBBC_Q4) && exec_q && is_brc && carry_r;
         o_flush <= (phase == cbbc_pkg::CBBC_Q4) && exec_q && is_brc && carry_r;
         if ((phase == cbbc_pkg::CBBC_Q4) && exec_q && is_brc && carry_r) begin
            o_pc_value <= br_target;
         end
      end
   end

   // ==========================================================
   // Bit clear path
   // Q2 read, Q3 modify, Q4 write back; flags never touched
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_dm_rd <= 1'b0;
         o_dm_wr <= 1'b0;
         o_dm_addr <= '0;
         o_dm_wdata <= 8'h00;
         mod_r <= 8'h00;
      end else begin
         o_dm_rd <= (phase == cbbc_pkg::CBBC_Q2) && exec_q && is_clr;
         o_dm_wr <= (phase == cbbc_pkg::CBBC_Q4) && exec_q && is_clr;
         if ((phase == cbbc_pkg::CBBC_Q2) && exec_q && is_clr) begin
            o_dm_addr <= op_addr;
         end
         if (o_dm_rd) begin
            mod_r <= i_dm_rdata & ~(8'h01 << bsel);
         end
         if ((phase == cbbc_pkg::CBBC_Q4) && exec_q && is_clr) begin
            o_dm_wdata <= mod_r;
         end
      end
   end

   // Activity counters for software
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         taken_cnt_r <= 16'h0000;
         clr_cnt_r <= 16'h0000;
      end else begin
         if (o_pc_load) begin
            taken_cnt_r <= taken_cnt_r + 16'h0001;
         end
         if (o_dm_wr) begin
            clr_cnt_r <= clr_cnt_r + 16'h0001;
         end
      end
   end

   // ==========================================================
   // AXI4-Lite write channel
   logic [31:0] wmask;  // Byte strobes as bit mask
   logic [31:0] ctrl_val;  // Current control word
   logic [31:0] bank_val;  // Current bank word
   logic [31:0] idxb_val;  // Current index base word
   logic [31:0] ctrl_new;  // Merged control word
   logic [31:0] bank_new;  // Merged bank word
   logic [31:0] idxb_new;  // Merged index base word

   assign wmask = {{8{i_wstrb[3]}}, {8{i_wstrb[2]}}, {8{i_wstrb[1]}}, {8{i_wstrb[0]}}};
   assign ctrl_val = {31'h0000_0000, ext_en_r};
   assign bank_val = {28'h000_0000, bank_r};
   assign idxb_val = {{(32-DA_W){1'b0}}, idx_base_r};
   assign ctrl_new = (ctrl_val & ~wmask) | (i_wdata & wmask);
   assign bank_new = (bank_val & ~wmask) | (i_wdata & wmask);
   assign idxb_new = (idxb_val & ~wmask) | (i_wdata & wmask);

   // Ready pulses once both halves wait; write at their handshake
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= `CBBC_RESP_OKAY;
      end else if (o_awready) begin
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         o_bvalid <= 1'b1;
         case (i_awaddr)
            `CBBC_OFF_CTRL, `CBBC_OFF_BANK, `CBBC_OFF_IDXB: o_bresp <= `CBBC_RESP_OKAY;
            `CBBC_OFF_STAT, `CBBC_OFF_CCNT: o_bresp <= `CBBC_RESP_OKAY;  // Read-only, ignored
            default: o_bresp <= `CBBC_RESP_SLVERR;
         endcase
      end else if (o_bvalid) begin
         o_bvalid <= !i_bready;
      end else if (i_awvalid && i_wvalid) begin
         o_awready <= 1'b1;
         o_wready <= 1'b1;
      end
   end

   // Configuration registers steer operand resolution
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         ext_en_r <= `CBBC_RST_CTRL;
         bank_r <= `CBBC_RST_BANK;
         idx_base_r <= `CBBC_RST_IDXB;
      end else if (o_awready) begin
         case (i_awaddr)
            `CBBC_OFF_CTRL: ext_en_r <= ctrl_new[`CBBC_CTRL_EXT_BIT];
            `CBBC_OFF_BANK: bank_r <= bank_new[3:0];
            `CBBC_OFF_IDXB: idx_base_r <= idxb_new[DA_W-1:0];
            default: ;  // Nothing stored
         endcase
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= `CBBC_RESP_OKAY;
      end else if (o_arready) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b1;
         o_rresp <= `CBBC_RESP_OKAY;
         case (i_araddr)
            `CBBC_OFF_CTRL: o_rdata <= ctrl_val;
            `CBBC_OFF_BANK: o_rdata <= bank_val;
            `CBBC_OFF_IDXB: o_rdata <= idxb_val;
            `CBBC_OFF_STAT: o_rdata <= {taken_cnt_r, 14'h0000, carry_r, !exec_q};
            `CBBC_OFF_CCNT: o_rdata <= {16'h0000, clr_cnt_r};
            default: begin
               o_rdata <= 32'h0000_0000;
               o_rresp <= `CBBC_RESP_SLVERR;
            end
         endcase
      end else if (o_rvalid) begin
         o_rvalid <= !i_rready;
      end else if (i_arvalid) begin
         o_arready <= 1'b1;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   logic [7:0] rd_seen_r;  // Value read for the bit clear
   logic [2:0] b_seen_r;  // Bit number of that clear
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         rd_seen_r <= 8'h00;
         b_seen_r <= 3'h0;
      end else if (o_dm_rd) begin
         rd_seen_r <= i_dm_rdata;
         b_seen_r <= bsel;
      end
   end

   property p_branch_target;
      (phase == cbbc_pkg::CBBC_Q4 && exec_q && is_brc && carry_r)
         |=> o_pc_load && o_pc_value == $past(br_target);
   endproperty
   a_branch_target: assert property (p_branch_target) else $error("bad branch target");

   sequence s_idle_cycle;
      (!o_pc_load && !o_dm_rd && !o_dm_wr) [*4];
   endsequence
   // The pulse cycle itself has o_pc_load high; the idle cycle follows it
   property p_taken_idle;
      o_pc_load |=> s_idle_cycle;
   endproperty
   a_taken_idle: assert property (p_taken_idle) else $error("idle cycle not idle");

   property p_no_jump;
      (phase == cbbc_pkg::CBBC_Q4 && exec_q && is_brc && !carry_r)
         |=> !o_pc_load ##1 (st_r == cbbc_pkg::CBBC_ST_EXEC);
   endproperty
   a_no_jump: assert property (p_no_jump) else $error("branch taken on clear carry");

   property p_clear_value;
      o_dm_wr |-> o_dm_wdata == (rd_seen_r & ~(8'h01 << b_seen_r));
   endproperty
   a_clear_value: assert property (p_clear_value) else $error("wrong cleared value");

   property p_access_bank;
      (phase == cbbc_pkg::CBBC_Q2 && exec_q && is_clr && !acc_a
         && !(ext_en_r && fadr <= `CBBC_IDX_MAX) && fadr < `CBBC_ACC_SPLIT)
         |=> o_dm_rd && o_dm_addr == DA_W'($past(fadr));
   endproperty
   a_access_bank: assert property (p_access_bank) else $error("access bank address");

   property p_indexed;
      (phase == cbbc_pkg::CBBC_Q2 && exec_q && is_clr && !acc_a && ext_en_r
         && fadr <= `CBBC_IDX_MAX)
         |=> o_dm_addr == DA_W'($past(idx_base_r) + DA_W'($past(fadr)));
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed address");

   sequence s_rmw;
      o_dm_rd ##1 (!o_dm_rd && !o_dm_wr) ##1 o_dm_wr;
   endsequence
   property p_rmw_order;
      o_dm_rd |-> s_rmw;
   endproperty
   a_rmw_order: assert property (p_rmw_order) else $error("read-modify-write order");

   property p_flush;
      o_pc_load |-> o_flush ##1 !o_flush;
   endproperty
   a_flush: assert property (p_flush) else $error("flush missing on taken branch");
endmodule

`default_nettype wire

// file: dv/tb_top.sv
/* Self-checking bench for the carry branch and bit clear block.
   Drives the fetch, memory and register bus ports and checks the outputs
   against a queue of notes. Assumes the package and the constants header
   are compiled first. */
`include "cbbc_defines.svh"
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Stimulus and observed ports
   logic i_mclk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [15:0] i_instr = 16'h0000;
   logic [20:0] i_pc = 21'h00_0000;
   logic i_carry = 1'b0;
   logic [7:0] i_dm_rdata = 8'h00;
   logic [11:0] i_awaddr = 12'h000;
   logic [11:0] i_araddr = 12'h000;
   logic [31:0] i_wdata = 32'h0000_0000;
   logic [3:0] i_wstrb = 4'h0;
   logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
   logic o_pc_load, o_flush, o_dm_rd, o_dm_wr, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [20:0] o_pc_value;
   logic [11:0] o_dm_addr;
   logic [7:0] o_dm_wdata;
   logic [1:0] o_bresp, o_rresp;
   logic [31:0] o_rdata;
   // ==========================================================
   // Bench state
   typedef struct {logic [1:0] kind; logic [33:0] val; logic [33:0] mask;} cbbc_note_t;
   cbbc_note_t notes[$];              // Oldest expected result first
   int bad_count = 0;
   int samples_checked = 0;
   logic [1:0] qn = 2'd0;             // Phase of the coming edge
   logic [31:0] seed_r = 32'h0000_1a14;
   logic [3:0] bank = 4'h0;           // Model of the bank selection register
   logic [11:0] idxb = 12'h000;       // Model of the index base
   logic ext = 1'b0;                  // Model of the extended set enable
   logic [15:0] taken = 16'h0000;     // Taken branches so far
   // Addresses on both sides of the indexed and access bank splits
   logic [7:0] corner [6] = '{8'h00, 8'h5f, 8'h60, 8'h7f, 8'h80, 8'hff};

   always #25 i_mclk = ~i_mclk;

   cbbc_core #(.PC_W(21), .DA_W(12)) i_dut (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_instr(i_instr), .i_pc(i_pc),
      .i_carry(i_carry), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_flush(o_flush),
      .o_dm_addr(o_dm_addr), .o_dm_rd(o_dm_rd), .i_dm_rdata(i_dm_rdata), .o_dm_wr(o_dm_wr),
      .o_dm_wdata(o_dm_wdata), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
      .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
      .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
      .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
      .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready)
   );

   // Phase tracker, so stimulus lines up with the quarter cycles
   always @(posedge i_mclk) qn <= i_sys_rst ? 2'd0 : qn + 2'd1;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // ==========================================================
   // Reporting and comparison
   task automatic miss(input string s);
      bad_count++;
      $display("mismatch at %0t: %s", $time, s);
   endtask

   task automatic wrap_up;
      if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic note(input logic [1:0] k, input logic [33:0] v, input logic [33:0] m);
      notes.push_back('{k, v, m});
   endtask

   // Pops the oldest note; an empty queue means an unasked-for result
   task automatic take(input logic [1:0] k, input logic [33:0] got);
      cbbc_note_t n;
      samples_checked++;
      if (notes.size() == 0) begin
         miss($sformatf("unexpected result kind %0d value %h", k, got));
      end else begin
         n = notes.pop_front();
         if (n.kind !== k || (got & n.mask) !== (n.val & n.mask))
            miss($sformatf("kind %0d got %h expected kind %0d %h", k, got, n.kind, n.val));
      end
   endtask

   task automatic chk_core(input logic [1:0] k, input logic [33:0] got);
      take(k, got);
   endtask

   task automatic chk_bus(input logic [33:0] got);
      take(2'd3, got);
   endtask

   // ==========================================================
   // Output watcher; the phase rides along so timing is checked too
   always @(posedge i_mclk) begin
      if (!i_sys_rst) begin
         if (o_pc_load === 1'b1 || o_flush === 1'b1)
            chk_core(2'd0, {10'h000, qn, o_flush, o_pc_value});
         if (o_dm_rd === 1'b1) chk_core(2'd1, {20'h0_0000, qn, o_dm_addr});
         if (o_dm_wr === 1'b1) chk_core(2'd2, {24'h00_0000, qn, o_dm_wdata});
         if (o_bvalid === 1'b1 && i_bready === 1'b1) chk_bus({o_bresp, 32'h0000_0000});
         if (o_rvalid === 1'b1 && i_rready === 1'b1) chk_bus({o_rresp, o_rdata});
      end
   end

   // ==========================================================
   // Register bus master
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      note(2'd3, {r, 32'h0000_0000}, 34'h3_ffff_ffff);
      @(posedge i_mclk);
      i_awaddr <= a;
      i_wdata <= d;
      i_wstrb <= 4'hf;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      do begin
         @(posedge i_mclk);
         if (o_awready === 1'b1) i_awvalid <= 1'b0;
         if (o_wready === 1'b1) i_wvalid <= 1'b0;
      end while (o_bvalid !== 1'b1);
      i_bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [33:0] v, input logic [33:0] m);
      note(2'd3, v, m);
      @(posedge i_mclk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do begin
         @(posedge i_mclk);
         if (o_arready === 1'b1) i_arvalid <= 1'b0;
      end while (o_rvalid !== 1'b1);
      i_rready <= 1'b0;
   endtask

   // ==========================================================
   // Instruction driver: presents a word for the coming Q1 edge
   task automatic issue(input logic [15:0] w, input logic [20:0] pc, input logic c,
                        input logic [7:0] d);
      do @(negedge i_mclk); while (qn !== 2'd3);
      @(posedge i_mclk);
      i_instr <= w;
      i_pc <= pc;
      i_carry <= c;
      i_dm_rdata <= d;
      @(posedge i_mclk);
      i_instr <= 16'h0000;             // Not an opcode, so nothing relatches
   endtask

   task automatic clr(input logic [2:0] b, input logic a, input logic [7:0] f);
      logic [11:0] ad;
      seed_r = lfsr(seed_r);
      if (a) ad = {bank, f};
      else if (ext && f <= `CBBC_IDX_MAX) ad = idxb + {4'h0, f};
      else if (f < `CBBC_ACC_SPLIT) ad = {4'h0, f};
      else ad = {`CBBC_ACC_HI_PAGE, f};
      note(2'd1, {20'h0_0000, 2'd2, ad}, 34'h3_ffff_ffff);
      note(2'd2, {24'h00_0000, 2'd0, seed_r[7:0] & ~(8'h01 << b)}, 34'h3_ffff_ffff);
      issue({`CBBC_OP_CLR, b, a, f}, seed_r[20:0], 1'b0, seed_r[7:0]);
   endtask

   task automatic branch(input logic [7:0] n, input logic c);
      logic [20:0] pc;
      seed_r = lfsr(seed_r);
      pc = {seed_r[20:1], 1'b0};
      if (c) begin
         note(2'd0, {10'h000, 2'd0, 1'b1, pc + `CBBC_PC_STEP + {{12{n[7]}}, n, 1'b0}},
              34'h3_ffff_ffff);
         taken++;
      end
      issue({`CBBC_OP_BRC, n}, pc, c, 8'h00);
      // The prefetched word in the idle cycle must come to nothing
      if (c) issue({`CBBC_OP_CLR, 3'd0, 1'b0, 8'h10}, pc, 1'b0, 8'hff);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (20) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      // Bank and index base, read back, then an unmapped place
      wr(`CBBC_OFF_BANK, 32'h0000_0005, `CBBC_RESP_OKAY);
      bank = 4'h5;
      wr(`CBBC_OFF_IDXB, 32'h0000_0123, `CBBC_RESP_OKAY);
      idxb = 12'h123;
      rd(`CBBC_OFF_BANK, {`CBBC_RESP_OKAY, 32'h0000_0005}, 34'h3_ffff_ffff);
      rd(`CBBC_OFF_IDXB, {`CBBC_RESP_OKAY, 32'h0000_0123}, 34'h3_ffff_ffff);
      wr(12'h014, 32'h0000_00ff, `CBBC_RESP_SLVERR);
      rd(12'h014, {`CBBC_RESP_SLVERR, 32'h0000_0000}, 34'h3_ffff_ffff);
      // Addressing corners, extended set off then on
      for (int e = 0; e < 2; e++) begin
         wr(`CBBC_OFF_CTRL, {31'h0000_0000, e[0]}, `CBBC_RESP_OKAY);
         ext = e[0];
         foreach (corner[i]) begin
            clr(seed_r[2:0], 1'b0, corner[i]);
            clr(seed_r[5:3], 1'b1, corner[i]);
         end
      end
      // Every bit position, back to back
      for (int b = 0; b < 8; b++) clr(b[2:0], 1'b1, seed_r[15:8]);
      // Offset extremes, taken and not taken, then a clear right behind
      branch(8'h80, 1'b1);
      branch(8'h7f, 1'b1);
      branch(8'h05, 1'b0);
      clr(3'd7, 1'b1, 8'h22);
      branch(8'h00, 1'b1);
      branch(8'hfb, 1'b0);
      clr(3'd0, 1'b0, 8'h81);
      // Status is read-only: a write is accepted and ignored
      wr(`CBBC_OFF_STAT, 32'hffff_ffff, `CBBC_RESP_OKAY);
      rd(`CBBC_OFF_STAT, {`CBBC_RESP_OKAY, taken, 16'h0000}, {2'b11, 16'hffff, 16'h0002});
      repeat (12) @(posedge i_mclk);
      samples_checked++;
      if (notes.size() != 0) miss("expected results never appeared");
      wrap_up;
   end

   // Watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #1000000;
      miss("watchdog expired");
      wrap_up;
   end
endmodule

`default_nettype wire
